// ### core/fmc_defs.svh
// register indices, field positions, reset values of the fault manager control block
// assumes a 32-bit classic Wishbone slave; byte address = 4 * register index
`ifndef FMC_DEFS_SVH
`define FMC_DEFS_SVH

`define FMC_IDX_CLEAR 16'hF421
`define FMC_IDX_MEMMASK 16'hF422
`define FMC_IDX_SWMASK 16'hF423
`define FMC_IDX_WDMASK 16'hF424
`define FMC_IDX_STKMASK 16'hF425
`define FMC_IDX_LOOPMASK 16'hF426
`define FMC_IDX_FLAG 16'hF427
`define FMC_IDX_CODE 16'hF428
`define FMC_IDX_IRQSTAT 16'hF429
`define FMC_IDX_IRQMASK 16'hF42A

`define FMC_MEMMASK_RESET 12'h003
`define FMC_ONEBIT_RESET 1'h0
`define FMC_IRQ_RESET 2'h0

`define FMC_SRC_SOFT 15
`define FMC_SRC_LOOP 14
`define FMC_SRC_STACK 13
`define FMC_SRC_WDOG 12
`define FMC_SRC_MEM_HI 11

`define FMC_IRQ_NEWFAULT 0
`define FMC_IRQ_LOSTERR 1

`endif

// ### core/fmc_pkg.sv
// types shared by the fault manager control block
// assumes nothing beyond a SystemVerilog compiler
package fmc_pkg;
  typedef enum logic {FMC_IDLE, FMC_HELD} fmc_state_t;
endpackage

// ### core/fmc_capture.sv
// sticky fault flag and first-error source code capture
// assumes reported errors are already masked and on the same clock
`timescale 1ns/1ps
`default_nettype none
module fmc_capture (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic [15:0] reportedErr,
  input wire logic clearEdge,
  output logic faultFlag,
  output logic [15:0] faultCode,
  output logic newFault,
  output logic lostErr
);
  fmc_pkg::fmc_state_t state;
  fmc_pkg::fmc_state_t next_state;
  logic [15:0] next_faultCode;
  wire anyErr = |reportedErr;

  always_comb begin
    next_state = state;
    next_faultCode = faultCode;
    newFault = 1'b0;
    lostErr = 1'b0;
    case (state)
      fmc_pkg::FMC_IDLE: begin
        if (anyErr) begin
          next_state = fmc_pkg::FMC_HELD;
          next_faultCode = reportedErr;
          newFault = 1'b1;
        end
      end
      fmc_pkg::FMC_HELD: begin
        if (clearEdge) begin
          // an error in the clearing cycle survives: set wins over clear
          next_state = anyErr ? fmc_pkg::FMC_HELD : fmc_pkg::FMC_IDLE;
          next_faultCode = reportedErr;
          newFault = anyErr;
        end else begin
          lostErr = anyErr;
        end
      end
      default: begin
        next_state = fmc_pkg::FMC_IDLE;
        next_faultCode = 16'h0000;
      end
    endcase
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      state <= fmc_pkg::FMC_IDLE;
      faultCode <= 16'h0000;
    end else if (ce) begin
      state <= next_state;
      faultCode <= next_faultCode;
    end
  end

  assign faultFlag = (state == fmc_pkg::FMC_HELD);
endmodule
`default_nettype wire

// ### core/fmc_fault_ctrl.sv
// fault manager control: suppress masks, clear register, flag and code readback
// assumes error strobes come from detectors on clk; software over classic Wishbone
//
// Register access over Wishbone was decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "fmc_defs.svh"
module fmc_fault_ctrl (
  input wire logic clk,
  input wire logic nrst,
  input wire logic ce,
  input wire logic wbCyc,
  input wire logic wbStb,
  input wire logic wbWe,
  input wire logic [17:0] wbAdr,
  input wire logic [3:0] wbSel,
  input wire logic [31:0] wbDatIn,
  output logic [31:0] wbDatOut,
  output logic wbAck,
  input wire logic [11:0] parityErr,
  input wire logic softPanicErr,
  input wire logic watchdogErr,
  input wire logic stackErr,
  input wire logic loopErr,
  output logic faultFlag,
  output logic irq
);
  // register state
  logic clearBit;
  logic clearPrev;
  logic [11:0] memSuppress;
  logic softwareSuppress;
  logic watchdog_error_suppress_bit;
  logic stackSuppress;
  logic loopSuppress;
  logic [1:0] irqStatus;
  logic [1:0] irqMask;
  logic [15:0] faultCode;
  logic newFault;
  logic lostErr;

  function automatic logic regHit(input logic [17:0] adr, input logic [15:0] idx);
    regHit = (adr[17:2] == idx);
  endfunction

  // only the two low byte lanes hold register bits
  function automatic logic [15:0] laneMerge(input logic [15:0] old, input logic [31:0] dat,
                                            input logic [3:0] sel);
    laneMerge = {sel[1] ? dat[15:8] : old[15:8], sel[0] ? dat[7:0] : old[7:0]};
  endfunction

  // bus decode
  wire busReq = wbCyc & wbStb;
  wire reqNew = busReq & ~wbAck;
  wire wrNow = busReq & wbAck & wbWe;
  wire hitClear = regHit(wbAdr, `FMC_IDX_CLEAR);
  wire hitMem = regHit(wbAdr, `FMC_IDX_MEMMASK);
  wire hitSw = regHit(wbAdr, `FMC_IDX_SWMASK);
  wire hitWd = regHit(wbAdr, `FMC_IDX_WDMASK);
  wire hitStk = regHit(wbAdr, `FMC_IDX_STKMASK);
  wire hitLoop = regHit(wbAdr, `FMC_IDX_LOOPMASK);
  wire hitFlag = regHit(wbAdr, `FMC_IDX_FLAG);
  wire hitCode = regHit(wbAdr, `FMC_IDX_CODE);
  wire hitIrqStat = regHit(wbAdr, `FMC_IDX_IRQSTAT);
  wire hitIrqMask = regHit(wbAdr, `FMC_IDX_IRQMASK);
  wire [15:0] memMerged = laneMerge({4'h0, memSuppress}, wbDatIn, wbSel);
  wire lowLaneWr = wrNow & wbSel[0];

  // masking: a set suppress bit stops the error before the latch
  wire [15:0] rawErr = {softPanicErr, loopErr, stackErr, watchdogErr, parityErr};
  wire [15:0] suppressVec = {softwareSuppress, loopSuppress, stackSuppress,
                             watchdog_error_suppress_bit, memSuppress};
  wire [15:0] reportedErr = rawErr & ~suppressVec;
  wire clearEdge = clearBit & ~clearPrev;

  // read mux; reserved bits come back as zero
  wire [15:0] readSel =
    hitClear ? {15'h0000, clearBit} :
    hitMem ? {4'h0, memSuppress} :
    hitSw ? {15'h0000, softwareSuppress} :
    hitWd ? {15'h0000, watchdog_error_suppress_bit} :
    hitStk ? {15'h0000, stackSuppress} :
    hitLoop ? {15'h0000, loopSuppress} :
    hitFlag ? {15'h0000, faultFlag} :
    hitCode ? faultCode :
    hitIrqStat ? {14'h0000, irqStatus} :
    hitIrqMask ? {14'h0000, irqMask} : 16'h0000;
  wire statusReadClr = reqNew & ~wbWe & hitIrqStat;
  wire [1:0] irqEvents = {lostErr, newFault};

  fmc_capture u_capture (
    .clk(clk),
    .nrst(nrst),
    .ce(ce),
    .reportedErr(reportedErr),
    .clearEdge(clearEdge),
    .faultFlag(faultFlag),
    .faultCode(faultCode),
    .newFault(newFault),
    .lostErr(lostErr)
  );

  // bus answer: ack one cycle after the request, dropped the cycle after
  always_ff @(posedge clk) begin
    if (!nrst) begin
      wbAck <= 1'b0;
      wbDatOut <= 32'h0000_0000;
    end else if (ce) begin
      wbAck <= reqNew;
      if (reqNew) begin
        wbDatOut <= {16'h0000, readSel};
      end
    end
  end

  // writes land on the edge that sees ack high
  always_ff @(posedge clk) begin
    if (!nrst) begin
      clearBit <= `FMC_ONEBIT_RESET;
      memSuppress <= `FMC_MEMMASK_RESET;
      softwareSuppress <= `FMC_ONEBIT_RESET;
      watchdog_error_suppress_bit <= `FMC_ONEBIT_RESET;
      stackSuppress <= `FMC_ONEBIT_RESET;
      loopSuppress <= `FMC_ONEBIT_RESET;
      irqMask <= `FMC_IRQ_RESET;
    end else if (ce) begin
      if (lowLaneWr & hitClear) begin
        clearBit <= wbDatIn[0];
      end
      if (wrNow & hitMem) begin
        memSuppress <= memMerged[11:0];
      end
      if (lowLaneWr & hitSw) begin
        softwareSuppress <= wbDatIn[0];
      end
      if (lowLaneWr & hitWd) begin
        watchdog_error_suppress_bit <= wbDatIn[0];
      end
      if (lowLaneWr & hitStk) begin
        stackSuppress <= wbDatIn[0];
      end
      if (lowLaneWr & hitLoop) begin
        loopSuppress <= wbDatIn[0];
      end
      if (lowLaneWr & hitIrqMask) begin
        irqMask <= wbDatIn[1:0];
      end
    end
  end

  // edge history of the clear bit and interrupt status
  always_ff @(posedge clk) begin
    if (!nrst) begin
      clearPrev <= 1'b0;
      irqStatus <= `FMC_IRQ_RESET;
      irq <= 1'b0;
    end else if (ce) begin
      clearPrev <= clearBit;
      // an event in the read-clear cycle is kept: set wins
      irqStatus <= (statusReadClr ? 2'b00 : irqStatus) | irqEvents;
      irq <= |(irqStatus & irqMask);
    end
  end

  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  sequence sIdle;
    ce && !faultFlag && !clearEdge;
  endsequence

  sequence sHeld;
    ce && faultFlag && !clearEdge;
  endsequence

  sequence sClearRise;
    ce && !clearBit ##1 ce && clearBit && !(|reportedErr);
  endsequence

  a_clear_rising_edge: assert property (
    sClearRise |=> !faultFlag && faultCode == 16'h0000)
    else $error("rising clear bit did not reset fault state");

  a_clear_held_high: assert property (
    faultFlag && clearBit && clearPrev |=> faultFlag)
    else $error("held clear bit cleared the fault flag");

  a_dm1_bank3_report: assert property (
    sIdle and (parityErr[11] && !memSuppress[11]) |=> faultFlag && faultCode[11])
    else $error("unsuppressed dm1 bank3 error not captured");

  a_dm0_bank0_report: assert property (
    sIdle and (parityErr[4] && !memSuppress[4]) |=> faultFlag && faultCode[4])
    else $error("unsuppressed dm0 bank0 error not captured");

  a_prog_mem_report: assert property (
    sIdle and (parityErr[3] && !memSuppress[3]) |=> faultFlag && faultCode[3])
    else $error("unsuppressed program memory error not captured");

  a_rate_conv_suppress: assert property (
    sIdle and (rawErr == 16'h0001 && memSuppress[0]) |=> !faultFlag)
    else $error("suppressed rate converter error was latched");

  a_mem_mask_reset: assert property (
    !$past(nrst) |-> memSuppress == `FMC_MEMMASK_RESET)
    else $error("memory suppress mask reset value wrong");

  a_soft_panic_report: assert property (
    sIdle and (softPanicErr && !softwareSuppress) |=> faultFlag && faultCode[`FMC_SRC_SOFT])
    else $error("software panic not captured in bit 15");

  a_watchdog_report: assert property (
    sIdle and (watchdogErr && !watchdog_error_suppress_bit)
      |=> faultFlag && faultCode[`FMC_SRC_WDOG])
    else $error("watchdog error not captured in bit 12");

  a_stack_report: assert property (
    sIdle and (stackErr && !stackSuppress) |=> faultFlag && faultCode[`FMC_SRC_STACK])
    else $error("stack overrun not captured in bit 13");

  a_loop_report: assert property (
    sIdle and (loopErr && !loopSuppress) |=> faultFlag && faultCode[`FMC_SRC_LOOP])
    else $error("loop overrun not captured in bit 14");

  a_flag_sticky: assert property (
    sHeld |=> faultFlag [*1] ##0 $stable(faultFlag))
    else $error("fault flag dropped without clear");

  a_code_first_only: assert property (
    sHeld |=> $stable(faultCode))
    else $error("fault code changed after first error");

  a_masked_not_latched: assert property (
    sIdle and (rawErr != 16'h0000 && (rawErr & suppressVec) == rawErr)
      |=> !faultFlag ##0 faultCode == 16'h0000)
    else $error("masked error left a trace");

  // the one-bit clear and suppress registers must show nothing above bit 0 whatever was written there
  a_reserved_zero: assert property (
    wbAck && !wbWe |-> wbDatOut[31:16] == 16'h0000 &&
      (!(hitClear || hitSw || hitWd || hitStk || hitLoop) || wbDatOut[15:1] == 15'h0000))
    else $error("reserved read bits not zero");

  a_mem_reserved_zero: assert property (
    wbAck && !wbWe && hitMem |-> wbDatOut[15:12] == 4'h0)
    else $error("reserved memory mask bits not zero");

  a_clear_fall_noop: assert property (
    ce && faultFlag && clearPrev && !clearBit |=> faultFlag)
    else $error("falling clear bit cleared the fault flag");

  a_dm1_bank0_report: assert property (
    sIdle and (parityErr[8] && !memSuppress[8]) |=> faultFlag && faultCode[8])
    else $error("unsuppressed dm1 bank0 error not captured");

  a_dm1_suppress: assert property (
    sIdle and (rawErr == 16'h0800 && memSuppress[11]) |=> !faultFlag)
    else $error("suppressed dm1 bank3 error was latched");

  a_dm0_bank3_report: assert property (
    sIdle and (parityErr[7] && !memSuppress[7]) |=> faultFlag && faultCode[7])
    else $error("unsuppressed dm0 bank3 error not captured");

  a_dm0_suppress: assert property (
    sIdle and (rawErr == 16'h0010 && memSuppress[4]) |=> !faultFlag)
    else $error("suppressed dm0 bank0 error was latched");

  a_prog_a_report: assert property (
    sIdle and (parityErr[2] && !memSuppress[2]) |=> faultFlag && faultCode[2])
    else $error("unsuppressed program memory a error not captured");

  a_prog_suppress: assert property (
    sIdle and (rawErr == 16'h0008 && memSuppress[3]) |=> !faultFlag)
    else $error("suppressed program memory b error was latched");

  a_rconv_b_report: assert property (
    sIdle and (parityErr[1] && !memSuppress[1]) |=> faultFlag && faultCode[1])
    else $error("unsuppressed rate converter b error not captured");

  a_mask_reset_others: assert property (
    !$past(nrst) |-> !softwareSuppress && !watchdog_error_suppress_bit &&
      !stackSuppress && !loopSuppress)
    else $error("one-bit suppress masks not zero after reset");

  a_soft_suppress: assert property (
    sIdle and (rawErr == 16'h8000 && softwareSuppress) |=> !faultFlag)
    else $error("suppressed software panic was latched");

  a_wdog_suppress: assert property (
    sIdle and (rawErr == 16'h1000 && watchdog_error_suppress_bit) |=> !faultFlag)
    else $error("suppressed watchdog error was latched");

  a_stack_suppress: assert property (
    sIdle and (rawErr == 16'h2000 && stackSuppress) |=> !faultFlag)
    else $error("suppressed stack overrun was latched");

  a_loop_suppress: assert property (
    sIdle and (rawErr == 16'h4000 && loopSuppress) |=> !faultFlag)
    else $error("suppressed loop overrun was latched");

  // simultaneous first errors must all land in the code together
  a_code_captured: assert property (
    sIdle and (reportedErr != 16'h0000) |=> faultCode == $past(reportedErr))
    else $error("fault code differs from the first reported errors");

  a_code_zero_idle: assert property (
    !faultFlag |-> faultCode == 16'h0000)
    else $error("fault code set while no fault is held");
endmodule
`default_nettype wire

// ### sim/fmc_fault_ctrl_tb_top.sv
// self-checking bench for the fault manager control block
// assumes the design answers classic Wishbone one cycle after a taken request
`timescale 1ns/1ps
`default_nettype none
`include "fmc_defs.svh"
`define CHK(got, exp) begin testsRun++; if ((got) !== (exp)) begin errCount++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp); end end
module fmc_fault_ctrl_tb_top;
  logic clk, nrst, ce, wbCyc, wbStb, wbWe, wbAck, faultFlag, irq;
  logic [17:0] wbAdr;
  logic [3:0] wbSel, busSel;
  logic [31:0] wbDatIn, wbDatOut, rng;
  logic [15:0] errVec, rd, idx;
  int errCount, testsRun, cycleCount, i, s, a, b;

  fmc_fault_ctrl DUT (.clk(clk), .nrst(nrst), .ce(ce), .wbCyc(wbCyc), .wbStb(wbStb),
    .wbWe(wbWe), .wbAdr(wbAdr), .wbSel(wbSel), .wbDatIn(wbDatIn), .wbDatOut(wbDatOut),
    .wbAck(wbAck), .parityErr(errVec[11:0]), .watchdogErr(errVec[12]),
    .stackErr(errVec[13]), .loopErr(errVec[14]), .softPanicErr(errVec[15]),
    .faultFlag(faultFlag), .irq(irq));

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  // code bit s maps to a suppress register and bit
  function automatic logic [15:0] mIdx(input int n);
    if (n < 12) return `FMC_IDX_MEMMASK;
    return n == 12 ? `FMC_IDX_WDMASK : n == 13 ? `FMC_IDX_STKMASK :
      n == 14 ? `FMC_IDX_LOOPMASK : `FMC_IDX_SWMASK;
  endfunction
  function automatic logic [15:0] mVal(input int n);
    return n < 12 ? 16'h0001 << n : 16'h0001;
  endfunction
  function automatic logic [15:0] rdExp(input logic [15:0] r, input logic [15:0] v);
    return r == `FMC_IDX_MEMMASK ? {4'h0, v[11:0]} : {15'h0000, v[0]};
  endfunction

  task automatic complete_run();
    $display("comparisons=%0d mismatches=%0d", testsRun, errCount);
    if (errCount == 0 && testsRun > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // the request is held until the edge that samples ack, then released for one idle cycle;
  // only the run timeout ends a wait for ack
  task automatic bus(input logic w, input logic [15:0] r, input logic [15:0] d,
                     output logic [15:0] q);
    wbCyc <= 1'b1;
    wbStb <= 1'b1;
    wbWe <= w;
    wbAdr <= {r, 2'b00};
    wbSel <= busSel;
    wbDatIn <= {16'h0000, d};
    do begin
      @(posedge clk);
    end while (wbAck !== 1'b1);
    q = wbDatOut[15:0];
    wbCyc <= 1'b0;
    wbStb <= 1'b0;
    @(posedge clk);
  endtask
  task automatic wr(input logic [15:0] r, input logic [15:0] d);
    logic [15:0] q;
    bus(1'b1, r, d, q);
  endtask
  task automatic rdb(input logic [15:0] r);
    bus(1'b0, r, 16'h0000, rd);
  endtask
  // strobe one source for a single cycle, then let flag and code settle
  task automatic pulse(input int n);
    errVec <= 16'h0001 << n;
    @(posedge clk);
    errVec <= 16'h0000;
    repeat (2) @(posedge clk);
  endtask
  // a clear needs a fresh rising edge, so the bit is always returned to zero
  task automatic clr();
    wr(`FMC_IDX_CLEAR, 16'h0001);
    wr(`FMC_IDX_CLEAR, 16'h0000);
  endtask

  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  always @(posedge clk) begin
    cycleCount++;
    if (cycleCount == 20000) begin
      errCount++;
      complete_run();
    end
  end

  initial begin
    nrst = 1'b0;
    wbCyc = 1'b0;
    wbStb = 1'b0;
    wbWe = 1'b0;
    wbAdr = 18'h00000;
    wbSel = 4'h0;
    wbDatIn = 32'h00000000;
    errVec = 16'h0000;
    ce = 1'b1;
    busSel = 4'hF;
    rng = 32'h74B1;
    repeat (3) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    for (i = 0; i < 6; i++) begin
      rdb(16'(`FMC_IDX_CLEAR + i));
      `CHK(rd, i == 1 ? 16'h0003 : 16'h0000)
    end
    `CHK(faultFlag, 1'b0)
    `CHK(irq, 1'b0)
    wr(`FMC_IDX_CLEAR, 16'hFFFE);
    rdb(`FMC_IDX_CLEAR);
    `CHK(rd, 16'h0000)
    repeat (10) begin
      rng = lfsr(rng);
      idx = 16'(`FMC_IDX_MEMMASK + rng[7:0] % 5);
      wr(idx, rng[31:16]);
      rdb(idx);
      `CHK(rd, rdExp(idx, rng[31:16]))
    end
    // byte lanes: each partial write must leave the other lane alone
    wr(`FMC_IDX_MEMMASK, 16'h0A00);
    busSel = 4'h1;
    wr(`FMC_IDX_MEMMASK, 16'h0F55);
    busSel = 4'h2;
    wr(`FMC_IDX_MEMMASK, 16'h0300);
    busSel = 4'hF;
    rdb(`FMC_IDX_MEMMASK);
    `CHK(rd, 16'h0355)
    for (i = 0; i < 5; i++) wr(16'(`FMC_IDX_MEMMASK + i), 16'h0000);
    for (s = 0; s < 16; s++) begin
      wr(mIdx(s), mVal(s));
      pulse(s);
      wr(mIdx(s), 16'h0000);
      `CHK(faultFlag, 1'b0)
      pulse(s);
      rdb(`FMC_IDX_CODE);
      `CHK(faultFlag, 1'b1)
      `CHK(rd, 16'h0001 << s)
      clr();
      `CHK(faultFlag, 1'b0)
    end
    repeat (6) begin
      rng = lfsr(rng);
      a = rng[3:0];
      b = (a + 1 + rng[7:4] % 15) % 16;
      pulse(a);
      pulse(b);
      rdb(`FMC_IDX_CODE);
      `CHK(rd, 16'h0001 << a)
      clr();
    end
    wr(`FMC_IDX_CLEAR, 16'h0001);
    repeat (3) @(posedge clk);
    pulse(5);
    repeat (4) @(posedge clk);
    `CHK(faultFlag, 1'b1)
    wr(`FMC_IDX_CLEAR, 16'h0000);
    repeat (3) @(posedge clk);
    `CHK(faultFlag, 1'b1)
    clr();
    rdb(`FMC_IDX_IRQSTAT);
    wr(`FMC_IDX_IRQMASK, 16'h0001);
    pulse(14);
    `CHK(irq, 1'b1)
    pulse(3);
    rdb(`FMC_IDX_IRQSTAT);
    `CHK(rd, 16'h0003)
    clr();
    rdb(`FMC_IDX_IRQSTAT);
    `CHK(rd, 16'h0000)
    `CHK(irq, 1'b0)
    wr(`FMC_IDX_IRQMASK, 16'h0000);
    pulse(14);
    `CHK(irq, 1'b0)
    clr();
    // a frozen block must not sample an error strobe
    ce <= 1'b0;
    pulse(6);
    ce <= 1'b1;
    @(posedge clk);
    `CHK(faultFlag, 1'b0)
    // a read-only place ignores writes; the code register with no fault held and an unmapped place read as zero
    wr(`FMC_IDX_CODE, 16'hFFFF);
    rdb(`FMC_IDX_CODE);
    `CHK(rd, 16'h0000)
    rdb(16'h0100);
    `CHK(rd, 16'h0000)
    complete_run();
  end
endmodule
`default_nettype wire
